/* rtl/rihc_ctl.sv */
`timescale 1ns/1ps
`default_nettype none

module rihc_ctl
	import rihc_pkg::*;
#(
	parameter int DATA_W = rihc_pkg::RIHC_BUS_W
) (
	// clock, reset, enable
	input  wire  logic              i_clk,
	input  wire  logic              i_reset,
	input  wire  logic              i_ce,
	// control bits
	input  wire  rihc_pkg::rihc_cfg_t i_cfg,
	// core request and answer
	input  wire  logic              i_req_valid,
	input  wire  rihc_pkg::rihc_req_t i_req,
	input  wire  logic [DATA_W-1:0] i_req_wdata,
	output logic                    o_req_ready,
	output logic                    o_done,
	output logic                    o_rd_valid,
	output logic [DATA_W-1:0]       o_rd_data,
	// memory and i/o pins
	input  wire  logic [DATA_W-1:0] i_data_in,
	output logic [DATA_W-1:0]       o_data_out,
	output logic                    o_data_oe_n,
	output logic                    o_bus_oe_n,
	output logic                    o_rom_select_n,
	output logic                    o_io_select_n,
	output logic                    o_rd_n,
	output logic                    o_wr_n,
	output logic                    o_mask0,
	output logic                    o_mask1,
	// hold handshake and reset switch pins
	input  wire  logic              i_hold_request_n,
	input  wire  logic              i_reset_switch_n,
	output logic                    o_hold_acknowledge_n,
	output logic                    o_hold_ack_oe_n
);
	import rihc_pkg::*;

	// ************************************************************
	// elaboration check
	// ************************************************************
	// the beat table assumes a 16-bit bus
	if (DATA_W != RIHC_BUS_W) begin : g_bad_width
		$error("rihc_ctl: only a 16-bit bus is served");
	end

	// ************************************************************
	// state
	// ************************************************************
	typedef enum logic [1:0] {
		rihc_s_idle,
		rihc_s_beat,
		rihc_s_hold
	} rihc_st_t;

	typedef struct packed {
		rihc_st_t          st;        // sequencer state
		rihc_mode_t        mode;      // mode latched at request start
		rihc_kind_t        kind;      // latched request kind
		logic [3:0]        cnt;       // cycles left in the beat, minus one
		logic [3:0]        beats;     // beats left after this one
		logic [DATA_W-1:0] smp1;      // data pin, first sync stage
		logic [DATA_W-1:0] smp2;      // data pin, second sync stage
		logic              tag1;      // smp1 holds an end-of-beat sample
		logic              tag2;      // smp2 holds an end-of-beat sample
		logic              hrq1;      // hold request sync
		logic              hrq2;
		logic              rsw1;      // reset switch sync
		logic              rsw2;
		logic              req_ready;
		logic              done;
		logic              rd_valid;
		logic [DATA_W-1:0] rd_data;
		logic [DATA_W-1:0] data_out;
		logic              data_oe_n;
		logic              bus_oe_n;
		logic              rom_sel_n;
		logic              io_sel_n;
		logic              rd_n;
		logic              wr_n;
		logic              mask0;
		logic              mask1;
		logic              ack_n;
		logic              ack_oe_n;
	} rihc_state_t;

	// reset picture: all strobes idle, acknowledge floating
	localparam rihc_state_t RIHC_RESET_STATE = '{
		st:        rihc_s_idle,
		mode:      rihc_m_normal,
		kind:      rihc_k_rom_rd,
		cnt:       RIHC_CNT_RESET,
		hrq1:      RIHC_STROBE_IDLE,
		hrq2:      RIHC_STROBE_IDLE,
		rsw1:      RIHC_STROBE_IDLE,
		rsw2:      RIHC_STROBE_IDLE,
		data_oe_n: RIHC_RELEASED,
		rom_sel_n: RIHC_STROBE_IDLE,
		io_sel_n:  RIHC_STROBE_IDLE,
		rd_n:      RIHC_STROBE_IDLE,
		wr_n:      RIHC_STROBE_IDLE,
		ack_n:     RIHC_STROBE_IDLE,
		ack_oe_n:  RIHC_RELEASED,
		default:   '0
	};

	rihc_state_t q;  // registered state
	rihc_state_t d;  // next state

	// ************************************************************
	// helper functions
	// ************************************************************
	// mode from the two control bits, flash bit dominant
	function automatic rihc_mode_t rom_mode(input rihc_cfg_t c);
		if (c.flash_write_enable_bit) begin
			rom_mode = rihc_m_flash;
		end else if (c.page_read_select_bit) begin
			rom_mode = rihc_m_page;
		end else begin
			rom_mode = rihc_m_normal;
		end
	endfunction : rom_mode

	// beats on the 16-bit bus minus one, per size code
	function automatic logic [3:0] extra_beats(input logic [2:0] sz);
		case (sz)
			3'h0:    extra_beats = 4'h0;  // 1 byte
			3'h1:    extra_beats = 4'h0;  // 2 bytes
			3'h2:    extra_beats = 4'h1;  // 3 bytes
			3'h3:    extra_beats = 4'h1;  // 1 word
			3'h4:    extra_beats = 4'h3;  // 2 words
			3'h5:    extra_beats = 4'h7;  // 4 words
			3'h6:    extra_beats = 4'hf;  // 8 words
			default: extra_beats = 4'h0;  // unused code runs as one beat
		endcase
	endfunction : extra_beats

	// beat length minus one
	function automatic logic [3:0] beat_len(input rihc_kind_t k, input rihc_mode_t m,
		input rihc_cfg_t c, input logic first);
		if (k == rihc_k_io_rd || k == rihc_k_io_wr) begin
			beat_len = RIHC_IO_CYC - 4'h1;
		end else if (m == rihc_m_flash) begin
			beat_len = RIHC_FLASH_CYC - 4'h1;
		end else if (m == rihc_m_page && !first) begin
			beat_len = {2'b00, c.page_access_wait} + RIHC_TPAGE_BASE - 4'h1;
		end else begin
			beat_len = {1'b0, c.rom_first_access_wait} + RIHC_TROM_BASE - 4'h1;
		end
	endfunction : beat_len

	// {mask1, mask0}; a lone byte raises one mask, any other size leaves both low
	function automatic logic [1:0] lane_mask(input logic big, input logic [2:0] sz,
		input logic a0);
		logic [1:0] le;
		le = 2'b00;
		if (sz == RIHC_SZ_BYTE1) begin
			le = a0 ? 2'b10 : 2'b01;
		end
		lane_mask = big ? {le[0], le[1]} : le;
	endfunction : lane_mask

	// ************************************************************
	// next-state logic
	// ************************************************************
	logic hold_ok;    // hold allowed by software and power state
	logic hold_want;  // synchronised request present and allowed

	always_comb begin
		d         = q;
		hold_ok   = i_cfg.hold_enable_bit && (i_cfg.pwr != rihc_p_deep);
		hold_want = hold_ok && !q.hrq2 && q.rsw2;
		// pin synchronisers; first stages feed only second stages
		d.smp1 = i_data_in;
		d.smp2 = q.smp1;
		d.hrq1 = i_hold_request_n;
		d.hrq2 = q.hrq1;
		d.rsw1 = i_reset_switch_n;
		d.rsw2 = q.rsw1;
		// sample tag travels beside the data through both stages
		d.tag1     = 1'b0;
		d.tag2     = q.tag1;
		d.rd_valid = q.tag2;
		if (q.tag2) begin
			d.rd_data = q.smp2;
		end
		d.done = 1'b0;
		// acknowledge floats while hold is off, after reset and in deep sleep
		d.ack_oe_n = !(hold_ok && (q.rsw2 || q.st == rihc_s_hold));
		case (q.st)
			rihc_s_idle: begin
				if (hold_want) begin
					// nothing is running here, so the grant is safe
					d.st        = rihc_s_hold;
					d.ack_n     = 1'b0;
					d.bus_oe_n  = RIHC_RELEASED;
					d.data_oe_n = RIHC_RELEASED;
					d.req_ready = 1'b0;
				end else if (i_req_valid && q.req_ready) begin
					d.st        = rihc_s_beat;
					d.kind      = i_req.kind;
					d.mode      = rom_mode(i_cfg);
					d.beats     = extra_beats(i_req.size);
					d.cnt       = beat_len(i_req.kind, rom_mode(i_cfg), i_cfg, 1'b1);
					d.req_ready = 1'b0;
					d.data_out  = i_req_wdata;
					if (i_req.kind == rihc_k_rom_rd || i_req.kind == rihc_k_rom_wr) begin
						d.rom_sel_n = 1'b0;
						d.rd_n      = (i_req.kind != rihc_k_rom_rd);
						// only flash mode may strobe a rom write
						d.wr_n      = !(i_req.kind == rihc_k_rom_wr &&
							rom_mode(i_cfg) == rihc_m_flash);
						d.data_oe_n = d.wr_n;
					end else begin
						d.io_sel_n  = 1'b0;
						d.rd_n      = (i_req.kind != rihc_k_io_rd);
						d.wr_n      = (i_req.kind != rihc_k_io_wr);
						d.data_oe_n = d.wr_n;
						{d.mask1, d.mask0} = lane_mask(i_cfg.big_endian, i_req.size,
							i_req.address_bit_zero);
					end
				end else begin
					d.req_ready = !hold_want;
				end
			end
			rihc_s_beat: begin
				if (q.cnt != 4'h0) begin
					d.cnt = q.cnt - 4'h1;
				end else begin
					// the edge closing this beat loads the sample stage
					d.tag1 = (q.kind == rihc_k_rom_rd || q.kind == rihc_k_io_rd);
					if (q.beats == 4'h0) begin
						d.st        = rihc_s_idle;
						d.done      = 1'b1;
						d.req_ready = 1'b0;
						d.rom_sel_n = RIHC_STROBE_IDLE;
						d.io_sel_n  = RIHC_STROBE_IDLE;
						d.rd_n      = RIHC_STROBE_IDLE;
						d.wr_n      = RIHC_STROBE_IDLE;
						d.data_oe_n = RIHC_RELEASED;
						d.mask0     = 1'b0;
						d.mask1     = 1'b0;
					end else begin
						// strobes stay low across beats; page reads rely on it
						d.beats = q.beats - 4'h1;
						d.cnt   = beat_len(q.kind, q.mode, i_cfg, 1'b0);
						d.mask0 = 1'b0;
						d.mask1 = 1'b0;
					end
				end
			end
			rihc_s_hold: begin
				if (!q.rsw2 || q.hrq2 || !hold_ok) begin
					// reset switch forces the acknowledge high and takes the bus back
					d.st       = rihc_s_idle;
					d.ack_n    = 1'b1;
					d.bus_oe_n = 1'b0;
				end
			end
			default: begin
				d.st = rihc_s_idle;
			end
		endcase
	end

	// ************************************************************
	// state register
	// ************************************************************
	// clock enable low freezes everything, synchronisers included
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q <= RIHC_RESET_STATE;
		end else if (i_ce) begin
			q <= d;
		end
	end

	// ************************************************************
	// outputs, straight from the state register
	// ************************************************************
	assign o_req_ready          = q.req_ready;
	assign o_done               = q.done;
	assign o_rd_valid           = q.rd_valid;
	assign o_rd_data            = q.rd_data;
	assign o_data_out           = q.data_out;
	assign o_data_oe_n          = q.data_oe_n;
	assign o_bus_oe_n           = q.bus_oe_n;
	assign o_rom_select_n       = q.rom_sel_n;
	assign o_io_select_n        = q.io_sel_n;
	assign o_rd_n               = q.rd_n;
	assign o_wr_n               = q.wr_n;
	assign o_mask0              = q.mask0;
	assign o_mask1              = q.mask1;
	assign o_hold_acknowledge_n = q.ack_n;
	assign o_hold_ack_oe_n      = q.ack_oe_n;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset || !i_ce);

	// lane masks never both high on an i/o beat
	a_mask_not_both: assert property (
		!o_io_select_n |-> !(o_mask0 && o_mask1))
		else $error("both lane masks high");

	// normal single-beat read with wait 000 holds select exactly three cycles
	a_normal_rom_len: assert property (
		(q.st == rihc_s_idle && d.st == rihc_s_beat && d.mode == rihc_m_normal &&
		 d.kind == rihc_k_rom_rd && d.beats == 4'h0 &&
		 i_cfg.rom_first_access_wait == 3'h0 && $stable(i_cfg))
		|=> !o_rom_select_n [*3] ##1 o_rom_select_n)
		else $error("normal rom beat length wrong");

	// data captured at the end of a read beat appears three edges on
	a_read_capture: assert property (
		(q.st == rihc_s_beat && q.cnt == 4'h0 &&
		 (q.kind == rihc_k_rom_rd || q.kind == rihc_k_io_rd))
		|-> ##3 o_rd_valid)
		else $error("read data not delivered");

	// a write strobe on a rom select only in flash mode
	a_rom_write_gate: assert property (
		(!o_wr_n && !o_rom_select_n) |-> q.mode == rihc_m_flash)
		else $error("rom write strobe outside flash mode");

	// page reads keep select and read low on every beat
	a_page_strobes: assert property (
		(q.st == rihc_s_beat && q.mode == rihc_m_page && q.kind == rihc_k_rom_rd)
		|-> (!o_rd_n && !o_rom_select_n))
		else $error("page burst strobe went high");

	// grant only from idle and only when allowed
	a_hold_grant: assert property (
		$fell(o_hold_acknowledge_n) |-> ($past(q.st) == rihc_s_idle) &&
		$past(i_cfg.hold_enable_bit) && ($past(i_cfg.pwr) != rihc_p_deep))
		else $error("hold granted without cause");

	// while granted the bus pins are released
	a_hold_release: assert property (
		!o_hold_acknowledge_n |-> (o_bus_oe_n && o_data_oe_n))
		else $error("bus driven during hold");

	// reset switch during hold retakes the bus next edge
	a_switch_retake: assert property (
		(q.st == rihc_s_hold && !q.rsw2) |=> (o_hold_acknowledge_n && !o_bus_oe_n))
		else $error("reset switch did not end hold");

	// acknowledge floats in deep sleep
	a_ack_float: assert property (
		(i_cfg.pwr == rihc_p_deep) |=> o_hold_ack_oe_n)
		else $error("acknowledge driven in deep sleep");

	c_normal_read: cover property (
		o_rd_valid && q.mode == rihc_m_normal);
	c_page_burst: cover property (
		q.st == rihc_s_beat && q.mode == rihc_m_page && q.beats == 4'h3);
	c_hold_grant: cover property (
		$fell(o_hold_acknowledge_n));
	c_switch_retake: cover property (
		q.st == rihc_s_hold && !q.rsw2);

endmodule : rihc_ctl

`default_nettype wire

/* inc/rihc_pkg.sv */
package rihc_pkg;

	// ************************************************************
	// cycle figures, counted in bus-clock periods
	// ************************************************************
	localparam logic [3:0] RIHC_TROM_BASE  = 4'h3;  // normal read, wait field 000
	localparam logic [3:0] RIHC_TPAGE_BASE = 4'h2;  // page beat, page wait field 00
	localparam logic [3:0] RIHC_FLASH_CYC  = 4'h4;  // fixed flash-mode beat length
	localparam logic [3:0] RIHC_IO_CYC     = 4'h3;  // fixed i/o beat length
	localparam int         RIHC_BUS_W      = 16;    // only width the beat table serves

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic       RIHC_STROBE_IDLE = 1'b1;   // strobes and selects idle high
	localparam logic       RIHC_RELEASED    = 1'b1;   // output enable high = pin let go
	localparam logic [3:0] RIHC_CNT_RESET   = 4'h0;

	// ************************************************************
	// request kinds, sizes, power states
	// ************************************************************
	typedef enum logic [1:0] {
		rihc_k_rom_rd,
		rihc_k_rom_wr,
		rihc_k_io_rd,
		rihc_k_io_wr
	} rihc_kind_t;

	// size code: 0..2 = 1..3 bytes, 3..6 = 1, 2, 4, 8 words
	localparam logic [2:0] RIHC_SZ_BYTE1 = 3'h0;
	localparam logic [2:0] RIHC_SZ_MAX   = 3'h6;

	typedef enum logic [1:0] {
		rihc_p_full,
		rihc_p_light,
		rihc_p_deep
	} rihc_pwr_t;

	typedef enum logic [1:0] {
		rihc_m_normal,
		rihc_m_page,
		rihc_m_flash
	} rihc_mode_t;

	// software settings, held steady by the owner of the control bits
	typedef struct packed {
		logic       flash_write_enable_bit;
		logic       page_read_select_bit;
		logic [2:0] rom_first_access_wait;
		logic [1:0] page_access_wait;
		logic       hold_enable_bit;
		logic       big_endian;
		rihc_pwr_t  pwr;
	} rihc_cfg_t;

	// one bus request from the core side
	typedef struct packed {
		rihc_kind_t kind;
		logic [2:0] size;
		logic       address_bit_zero;
	} rihc_req_t;

endpackage : rihc_pkg

/* tb/rihc_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// far side: rom/io device on the data pins, plus the hold master
// ************************************************************
module rihc_far_side #(
	parameter logic [15:0] DV = 16'h5a3c  // word the device returns on reads
) (
	// memory pins seen from the far side
	input  wire  logic        i_rom_select_n,
	input  wire  logic        i_io_select_n,
	input  wire  logic        i_rd_n,
	output logic [15:0]       o_data,
	// hold master controls
	input  wire  logic        i_want,
	input  wire  logic        i_sw,
	input  wire  logic        i_hold_enabled,
	input  wire  logic        i_hold_acknowledge_n,
	output logic              o_hold_request_n,
	output logic              o_reset_switch_n,
	output logic              o_granted
);
	// device drives only while selected and read; released pins show the
	// inverse so a late sample cannot pass by luck
	assign o_data = (!i_rd_n && (!i_rom_select_n || !i_io_select_n)) ? DV : ~DV;
	// request is active low
	assign o_hold_request_n = !i_want;
	// the bench raises the switch only in the retake test, where it means to
	// elsewhere switch and request never overlap
	assign o_reset_switch_n = !i_sw;
	// acknowledge ignored until software enables hold
	assign o_granted = i_hold_enabled && !i_hold_acknowledge_n;
endmodule : rihc_far_side

`default_nettype wire

/* tb/rom_io_bus_cycle_hold_ctl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module rom_io_bus_cycle_hold_ctl_tb;
	import rihc_pkg::*;
	// ************************************************************
	// signals
	// ************************************************************
	localparam logic [15:0] DV = 16'h5a3c;        // device read word
	localparam int BEATS[7] = '{1, 1, 2, 2, 4, 8, 16};
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	rihc_cfg_t   cfg = '0;
	rihc_req_t   req = '0;
	logic        vld = 1'b0;
	logic        want = 1'b0;
	logic        sw = 1'b0;
	logic        ready, done, rdv, doe_n, bus_oe_n, rs_n, is_n, rd_n, wr_n;
	logic        m0, m1, ack_n, ack_oe_n, hrq_n, rsw_n, granted;
	logic [15:0] rdata, dout, din;
	int          miscompares = 0;
	int          num_checks = 0;
	int          n_sel, n_rd, n_wr, n_rdv, n_rise, n_bad;  // per-run counts
	logic [1:0]  mask1st;                                  // masks of first i/o beat

	always #20 i_clk = ~i_clk;

	rihc_ctl rihc_ctl_inst (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_cfg(cfg),
		.i_req_valid(vld), .i_req(req), .i_req_wdata(16'hc35a), .o_req_ready(ready),
		.o_done(done), .o_rd_valid(rdv), .o_rd_data(rdata), .i_data_in(din),
		.o_data_out(dout), .o_data_oe_n(doe_n), .o_bus_oe_n(bus_oe_n),
		.o_rom_select_n(rs_n), .o_io_select_n(is_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_mask0(m0), .o_mask1(m1), .i_hold_request_n(hrq_n), .i_reset_switch_n(rsw_n),
		.o_hold_acknowledge_n(ack_n), .o_hold_ack_oe_n(ack_oe_n));

	rihc_far_side #(.DV(DV)) rihc_far_side_inst (.i_rom_select_n(rs_n), .i_io_select_n(is_n),
		.i_rd_n(rd_n), .o_data(din), .i_want(want), .i_sw(sw),
		.i_hold_enabled(cfg.hold_enable_bit), .i_hold_acknowledge_n(ack_n),
		.o_hold_request_n(hrq_n), .o_reset_switch_n(rsw_n), .o_granted(granted));

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one request, held until taken; pins are counted until two cycles after done
	task automatic run(input rihc_kind_t k, input logic [2:0] sz, input logic a0);
		int t;
		logic lo;
		logic seen;
		logic got;
		n_sel = 0;
		n_rd = 0;
		n_wr = 0;
		n_rdv = 0;
		n_rise = 0;
		n_bad = 0;
		lo = 1'b0;
		seen = 1'b0;
		got = 1'b0;
		@(posedge i_clk);
		#1;
		req = '{k, sz, a0};
		vld = 1'b1;
		t = 0;
		while (ready !== 1'b1 && t < 400) begin
			@(posedge i_clk);
			#1;
			t++;
		end
		@(posedge i_clk);
		#1;
		vld = 1'b0;
		t = 0;
		while (t < 400) begin
			n_sel += int'(!rs_n || !is_n);
			n_rd += int'(!rd_n);
			n_wr += int'(!wr_n);
			n_rdv += int'(rdv);
			n_rise += int'(lo && rd_n);
			lo = !rd_n;
			n_bad += int'(bus_oe_n && (!rs_n || !is_n));
			n_bad += int'(m0 && m1);
			if (rdv === 1'b1) chk("read data", DV, rdata);
			if (wr_n === 1'b0) chk("write data", 16'hc35a, dout);
			if (wr_n === 1'b0) chk("write drive", 0, 16'(doe_n));
			if (!is_n && !seen) begin
				mask1st = {m0, m1};
				seen = 1'b1;
			end
			if (done === 1'b1) begin
				got = 1'b1;
				t = 397;
			end
			@(posedge i_clk);
			#1;
			t++;
		end
		chk("done", 1, 16'(got));
	endtask : run

	// ask for the bus, look at the pins, then give it back
	task automatic hold_try(input logic en, input rihc_pwr_t pw, input logic exp);
		cfg.hold_enable_bit = en;
		cfg.pwr = pw;
		want = 1'b1;
		repeat (6) @(posedge i_clk);
		#1;
		chk("bus released", 16'(exp), 16'(bus_oe_n));
		chk("granted", 16'(exp), 16'(granted));
		// no sdram sits on this bench, so no self-refresh precedes the release
		want = 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
		chk("bus retaken", 0, 16'(bus_oe_n));
	endtask : hold_try

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (16) @(posedge i_clk);
		#1;
		i_reset = 1'b0;
		chk("ack float", 1, 16'(ack_oe_n));
		chk("select idle", 1, 16'(rs_n));
		// normal mode: beat tracks the wait field
		for (int w = 0; w < 8; w++) begin
			cfg.rom_first_access_wait = 3'(w);
			run(rihc_k_rom_rd, RIHC_SZ_BYTE1, 1'b0);
			chk("normal beat", 16'(w + 3), 16'(n_sel));
			chk("read beats", 1, 16'(n_rdv));
		end
		$display("test normal_wait done");
		cfg.rom_first_access_wait = 3'h0;
		for (int s = 0; s < 7; s++) begin
			run(rihc_k_rom_rd, 3'(s), 1'b0);
			chk("size beats", 16'(BEATS[s]), 16'(n_rdv));
			chk("size cycles", 16'(3 * BEATS[s]), 16'(n_sel));
		end
		run(rihc_k_rom_wr, 3'h1, 1'b0);
		chk("normal write strobe", 0, 16'(n_wr));
		$display("test sizes done");
		// page mode: first beat, then short page beats, strobe never lifts
		cfg.page_read_select_bit = 1'b1;
		cfg.rom_first_access_wait = 3'h1;
		for (int p = 0; p < 4; p++) begin
			cfg.page_access_wait = 2'(p);
			run(rihc_k_rom_rd, 3'h4, 1'b0);
			chk("page cycles", 16'(4 + 3 * (p + 2)), 16'(n_sel));
			chk("page strobe", 1, 16'(n_rise));
		end
		$display("test page done");
		// flash mode: fixed beat whatever the wait fields say
		cfg.flash_write_enable_bit = 1'b1;
		cfg.rom_first_access_wait = 3'h7;
		run(rihc_k_rom_wr, 3'h1, 1'b0);
		chk("flash write", 16'(RIHC_FLASH_CYC), 16'(n_wr));
		run(rihc_k_rom_rd, 3'h1, 1'b0);
		chk("flash read", 16'(RIHC_FLASH_CYC), 16'(n_sel));
		$display("test flash done");
		// lane masks for both byte orders, both address halves, read and write
		for (int i = 0; i < 8; i++) begin
			cfg.big_endian = i[1];
			run(i[2] ? rihc_k_io_wr : rihc_k_io_rd, RIHC_SZ_BYTE1, i[0]);
			chk("lane masks", (i[0] ^ i[1]) ? 16'h1 : 16'h2, 16'(mask1st));
			chk("mask clash", 0, 16'(n_bad));
		end
		$display("test masks done");
		// hold: enable, power state, switch retake, wait for running cycle
		hold_try(1'b0, rihc_p_full, 1'b0);
		hold_try(1'b1, rihc_p_deep, 1'b0);
		hold_try(1'b1, rihc_p_light, 1'b1);
		hold_try(1'b1, rihc_p_full, 1'b1);
		want = 1'b1;
		repeat (6) @(posedge i_clk);
		#1;
		chk("data released", 1, 16'(doe_n));
		sw = 1'b1;
		repeat (4) @(posedge i_clk);
		#1;
		chk("switch bus back", 0, 16'(bus_oe_n));
		chk("switch ack high", 1, 16'(ack_n));
		sw = 1'b0;
		want = 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
		cfg.flash_write_enable_bit = 1'b0;
		cfg.page_read_select_bit = 1'b0;
		fork
			run(rihc_k_rom_rd, RIHC_SZ_BYTE1, 1'b0);
			begin
				repeat (4) @(posedge i_clk);
				#1;
				want = 1'b1;
			end
		join
		chk("grant mid cycle", 0, 16'(n_bad));
		chk("cycle finished", 10, 16'(n_sel));
		repeat (4) @(posedge i_clk);
		#1;
		chk("grant after cycle", 1, 16'(bus_oe_n));
		want = 1'b0;
		$display("test hold done");
		finish_test();
	end

	// watchdog: all tests need well under a thousand cycles
	initial begin
		#(40 * 20000);
		miscompares++;
		finish_test();
	end
endmodule : rom_io_bus_cycle_hold_ctl_tb

`default_nettype wire
